// ==== flm_top.sv ====
/*
  Fiber link monitor: per-port mode, echo supervision, segmentation,
  fault contact, electrical segmentation gate and AHB-Lite registers.
  Assumes frame events from the repeater datapath on hclk, and a single
  AHB-Lite master doing word transfers.
*/
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - Monitored mode enables echo, supervision, segmentation
// - Link fault segments the fiber link
// - Fault lights port red, closes fault contact
// - Good test frames both ways lift segmentation
// - Unmonitored mode: no echo, supervision, segmentation
// - Dark monitored port reports break; unmonitored doesn't
// - Monitor-off switch disables electrical port segmentation
// - Mismatched ends behave as unmonitored
// - Optical mode resets to monitored line
// - Echo return sends received frame back
// - Missing echo after timeout flags echo error
// - Receiver isolated until echo received
// - Segmented port sends periodic test frames
module flm_top #(
  parameter int NPORT          = 2,
  parameter int ECHO_WAIT_BITS = flm_pkg::ECHO_WAIT_BITS,
  parameter int TEST_INT_BITS  = flm_pkg::TEST_INT_BITS
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [31:0]                      hrdata,
  output logic                             hresp,
  input  wire logic [3:0]                  rate_sel,
  input  wire flm_pkg::flm_rx_t [NPORT-1:0] opt_rx,
  input  wire logic [NPORT-1:0]            opt_tx_start,
  output flm_pkg::flm_po_t [NPORT-1:0]     opt_ctl,
  input  wire logic                        el_seg_req,
  output logic                             el_seg,
  output logic                             fault_contact,
  output logic                             irq
);

  localparam int EVN = NPORT * flm_pkg::EV_W;
  localparam logic [flm_pkg::CNT_W-1:0] ECHO_W =
    flm_pkg::CNT_W'(ECHO_WAIT_BITS);
  localparam logic [flm_pkg::CNT_W-1:0] TEST_W =
    flm_pkg::CNT_W'(TEST_INT_BITS);

  // Bus state
  logic                     wr_pend_r;
  logic                     wr_pend_nxt;
  logic [11:0]              wr_addr_r;
  logic [11:0]              wr_addr_nxt;
  logic [31:0]              rdata_nxt;
  logic                     addr_ok;

  // Register state
  logic [NPORT-1:0]         mon_r;
  logic [NPORT-1:0]         mon_nxt;
  logic                     moff_r;
  logic                     moff_nxt;
  logic [EVN-1:0]           istat_r;
  logic [EVN-1:0]           istat_nxt;
  logic [EVN-1:0]           imask_r;
  logic [EVN-1:0]           imask_nxt;
  logic                     el_seg_nxt;
  logic                     fault_nxt;
  logic                     irq_nxt;

  // Port wiring
  logic                     tick;
  flm_pkg::flm_ev_t [NPORT-1:0] ev;
  logic [EVN-1:0]           ev_set;
  logic [EVN-1:0]           ev_clr;
  logic [NPORT-1:0]         seg_v;
  logic [NPORT-1:0]         red_v;
  logic [31:0]              status_w;

  flm_bit_tick u_tick (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .rate_sel (rate_sel),
    .tick     (tick)
  );

  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      flm_port #(
        .CW (flm_pkg::CNT_W)
      ) u_port (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .tick           (tick),
        .mon_en         (mon_r[g]),
        .tx_start       (opt_tx_start[g]),
        .rx             (opt_rx[g]),
        .echo_wait_bits (ECHO_W),
        .test_int_bits  (TEST_W),
        .po             (opt_ctl[g]),
        .ev             (ev[g])
      );
      assign ev_set[g*flm_pkg::EV_W +: flm_pkg::EV_W] = ev[g];
      assign seg_v[g] = opt_ctl[g].seg;
      assign red_v[g] = opt_ctl[g].led_red;
    end
  endgenerate

  // Address phase decode
  always_comb
  begin
    addr_ok     = hsel & hready & htrans[1];
    wr_pend_nxt = addr_ok & hwrite;
    wr_addr_nxt = addr_ok ? haddr[11:0] : wr_addr_r;
  end

  always_comb
  begin
    status_w = 32'h0000_0000;
    status_w[flm_pkg::ST_SEG_LSB +: NPORT] = seg_v;
    status_w[flm_pkg::ST_RED_LSB +: NPORT] = red_v;
    status_w[flm_pkg::ST_FAULT_BIT]        = fault_contact;
    status_w[flm_pkg::ST_ELSEG_BIT]        = el_seg;
  end

  // Read data captured in the address phase, shown in the data phase
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (addr_ok && !hwrite)
    begin
      if (haddr[11:0] == flm_pkg::OFF_CTRL)
      begin
        rdata_nxt[flm_pkg::CTRL_MON_LSB +: NPORT] = mon_r;
        rdata_nxt[flm_pkg::CTRL_MOFF_BIT]         = moff_r;
      end
      else if (haddr[11:0] == flm_pkg::OFF_STATUS)
        rdata_nxt = status_w;
      else if (haddr[11:0] == flm_pkg::OFF_IRQ_STAT)
        rdata_nxt[EVN-1:0] = istat_r;
      else if (haddr[11:0] == flm_pkg::OFF_IRQ_MASK)
        rdata_nxt[EVN-1:0] = imask_r;
      else
        rdata_nxt = 32'h0000_0000;
    end
  end

  // Data phase writes
  always_comb
  begin
    mon_nxt   = mon_r;
    moff_nxt  = moff_r;
    imask_nxt = imask_r;
    ev_clr    = '0;
    if (wr_pend_r)
    begin
      if (wr_addr_r == flm_pkg::OFF_CTRL)
      begin
        mon_nxt  = hwdata[flm_pkg::CTRL_MON_LSB +: NPORT];
        moff_nxt = hwdata[flm_pkg::CTRL_MOFF_BIT];
      end
      else if (wr_addr_r == flm_pkg::OFF_IRQ_STAT)
        ev_clr = hwdata[EVN-1:0];
      else if (wr_addr_r == flm_pkg::OFF_IRQ_MASK)
        imask_nxt = hwdata[EVN-1:0];
      else
        ev_clr = '0;
    end
    // New events win over a clear in the same cycle
    istat_nxt  = (istat_r & ~ev_clr) | ev_set;
    el_seg_nxt = el_seg_req & ~moff_nxt;
    fault_nxt  = |red_v;
    irq_nxt    = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r     <= 1'b0;
      wr_addr_r     <= 12'h000;
      hrdata        <= 32'h0000_0000;
      mon_r         <= {NPORT{flm_pkg::CTRL_MON_RST}};
      moff_r        <= flm_pkg::CTRL_MOFF_RST;
      istat_r       <= '0;
      imask_r       <= '0;
      el_seg        <= 1'b0;
      fault_contact <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      wr_pend_r     <= wr_pend_nxt;
      wr_addr_r     <= wr_addr_nxt;
      hrdata        <= rdata_nxt;
      mon_r         <= mon_nxt;
      moff_r        <= moff_nxt;
      istat_r       <= istat_nxt;
      imask_r       <= imask_nxt;
      el_seg        <= el_seg_nxt;
      fault_contact <= fault_nxt;
      irq           <= irq_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // flm_top

// ==== flm_pkg.sv ====
/*
  Shared constants and types of the fiber link monitor block.
  Assumes a 50 MHz system clock and AHB-Lite word access to registers.
*/
package flm_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int NRATE  = 10;

  // Bus bit rates in bit/s, and one bit time in clock cycles
  localparam int RATE_BPS [NRATE] = '{9600, 19200, 45450, 93750, 187500,
                                      500000, 1500000, 3000000, 6000000,
                                      12000000};
  localparam int BIT_CYC [NRATE] = '{CLK_HZ / 9600, CLK_HZ / 19200,
                                     CLK_HZ / 45450, CLK_HZ / 93750,
                                     CLK_HZ / 187500, CLK_HZ / 500000,
                                     CLK_HZ / 1500000, CLK_HZ / 3000000,
                                     CLK_HZ / 6000000, CLK_HZ / 12000000};

  // Echo wait and test frame interval in bit times
  localparam int ECHO_WAIT_BITS = 64;
  localparam int TEST_INT_BITS  = 4096;
  localparam int CNT_W          = 16;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;

  // Field positions
  localparam int CTRL_MON_LSB  = 0;
  localparam int CTRL_MOFF_BIT = 8;
  localparam int ST_SEG_LSB    = 0;
  localparam int ST_RED_LSB    = 8;
  localparam int ST_FAULT_BIT  = 16;
  localparam int ST_ELSEG_BIT  = 17;
  localparam int EV_W          = 3;

  // Reset values
  localparam logic CTRL_MON_RST  = 1'b1;
  localparam logic CTRL_MOFF_RST = 1'b0;

  // Frame events reported by the receive path of one optical port
  typedef struct packed {
    logic frame;
    logic echo;
    logic err;
    logic test;
    logic peer_mon;
    logic peer_ok;
  } flm_rx_t;

  // Control outputs toward the datapath of one optical port
  typedef struct packed {
    logic echo_ret_en;
    logic rx_isolate;
    logic seg;
    logic led_red;
    logic send_test;
    logic test_ok;
  } flm_po_t;

  // One-cycle events of one optical port
  typedef struct packed {
    logic rel;
    logic seg;
    logic echo_err;
  } flm_ev_t;

  typedef enum logic [1:0] {ST_OK, ST_WAIT, ST_SEG} flm_st_t;

endpackage

// ==== flm_bit_tick.sv ====
/*
  Bit time prescaler: one pulse per bus bit time.
  Assumes rate_sel comes from the rate detector on the same clock.
*/
`timescale 1ns/1ns
module flm_bit_tick (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] rate_sel,
  output logic            tick
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] period;
  logic        tick_nxt;

  always_comb
  begin
    if (rate_sel < 4'(flm_pkg::NRATE))
      period = 16'(flm_pkg::BIT_CYC[rate_sel]);
    else
      period = 16'(flm_pkg::BIT_CYC[0]);
    tick_nxt = (cnt_r >= period - 16'h0001);
    cnt_nxt  = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule // flm_bit_tick

// ==== flm_port.sv ====
/*
  Echo supervision and segmentation of one optical port.
  Assumes frame events and tx_start are one-cycle pulses on hclk.
*/
`timescale 1ns/1ns
module flm_port #(
  parameter int CW = flm_pkg::CNT_W
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            tick,
  input  wire logic            mon_en,
  input  wire logic            tx_start,
  input  wire flm_pkg::flm_rx_t rx,
  input  wire logic [CW-1:0]   echo_wait_bits,
  input  wire logic [CW-1:0]   test_int_bits,
  output flm_pkg::flm_po_t     po,
  output flm_pkg::flm_ev_t     ev
);

  flm_pkg::flm_st_t st_r;
  flm_pkg::flm_st_t st_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic [CW-1:0]    int_r;
  logic [CW-1:0]    int_nxt;
  logic             pmon_r;
  logic             pmon_nxt;
  logic             lok_r;
  logic             lok_nxt;
  logic             eff;
  logic             test_nxt;
  flm_pkg::flm_ev_t ev_nxt;
  flm_pkg::flm_po_t po_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    int_nxt  = int_r;
    pmon_nxt = pmon_r;
    lok_nxt  = lok_r;
    test_nxt = 1'b0;
    ev_nxt   = '0;
    if (rx.frame)
      pmon_nxt = rx.peer_mon;
    eff = mon_en & pmon_r;
    case (st_r)
      flm_pkg::ST_OK:
      begin
        lok_nxt = 1'b0;
        if (rx.frame)
          int_nxt = '0;
        if (eff && tx_start)
        begin
          st_nxt  = flm_pkg::ST_WAIT;
          cnt_nxt = '0;
        end
        else if (eff && tick)
        begin
          if (int_r >= test_int_bits)
          begin
            // Idle line: probe the link so a dark port shows a break
            int_nxt  = '0;
            test_nxt = 1'b1;
            st_nxt   = flm_pkg::ST_WAIT;
            cnt_nxt  = '0;
          end
          else
            int_nxt = int_r + 1'b1;
        end
      end
      flm_pkg::ST_WAIT:
      begin
        if (!eff)
          st_nxt = flm_pkg::ST_OK;
        else if (rx.echo && !rx.err)
        begin
          st_nxt  = flm_pkg::ST_OK;
          int_nxt = '0;
        end
        else if (rx.err || cnt_r >= echo_wait_bits)
        begin
          st_nxt          = flm_pkg::ST_SEG;
          ev_nxt.echo_err = ~rx.err;
          ev_nxt.seg      = 1'b1;
          int_nxt         = '0;
          lok_nxt         = 1'b0;
        end
        else if (tick)
          cnt_nxt = cnt_r + 1'b1;
      end
      flm_pkg::ST_SEG:
      begin
        if (!eff)
        begin
          st_nxt     = flm_pkg::ST_OK;
          ev_nxt.rel = 1'b1;
        end
        else
        begin
          if (tick)
          begin
            if (int_r >= test_int_bits)
            begin
              int_nxt  = '0;
              test_nxt = 1'b1;
            end
            else
              int_nxt = int_r + 1'b1;
          end
          if (rx.err)
            lok_nxt = 1'b0;
          else if (rx.test)
          begin
            lok_nxt = 1'b1;
            if (rx.peer_ok)
            begin
              st_nxt     = flm_pkg::ST_OK;
              ev_nxt.rel = 1'b1;
              int_nxt    = '0;
            end
          end
        end
      end
      default: st_nxt = flm_pkg::ST_OK;
    endcase
    po_nxt.echo_ret_en = mon_en & pmon_nxt;
    po_nxt.rx_isolate  = po_nxt.echo_ret_en &
                         (st_nxt == flm_pkg::ST_WAIT);
    po_nxt.seg         = (st_nxt == flm_pkg::ST_SEG);
    po_nxt.led_red     = (st_nxt == flm_pkg::ST_SEG);
    po_nxt.send_test   = test_nxt;
    po_nxt.test_ok     = lok_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r   <= flm_pkg::ST_OK;
      cnt_r  <= '0;
      int_r  <= '0;
      pmon_r <= 1'b1;
      lok_r  <= 1'b0;
      po     <= '0;
      ev     <= '0;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      int_r  <= int_nxt;
      pmon_r <= pmon_nxt;
      lok_r  <= lok_nxt;
      po     <= po_nxt;
      ev     <= ev_nxt;
    end
  end

endmodule // flm_port

// ==== flm_chk_sva.sv ====
/*
  Checker of the fiber link monitor, optical port 0 and shared outputs.
  Assumes one clock domain; bound to flm_top below.
*/
`timescale 1ns/1ns
module flm_chk #(
  parameter int NPORT          = 2,
  parameter int ECHO_WAIT_BITS = 4
) (
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic [3:0]                   rate_sel,
  input wire flm_pkg::flm_rx_t [NPORT-1:0] opt_rx,
  input wire logic [NPORT-1:0]             opt_tx_start,
  input wire flm_pkg::flm_po_t [NPORT-1:0] opt_ctl,
  input wire logic                         el_seg_req,
  input wire logic                         el_seg,
  input wire logic                         fault_contact
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  flm_pkg::flm_po_t c0;
  flm_pkg::flm_rx_t r0;
  logic             red_any;
  int               bc;
  int               iso_r;
  int               iso_nxt;
  assign c0 = opt_ctl[0];
  assign r0 = opt_rx[0];
  assign bc = flm_pkg::BIT_CYC[(rate_sel > 4'h9) ? 4'h0 : rate_sel];
  always_comb
  begin
    red_any = 1'b0;
    for (int i = 0; i < NPORT; i++)
      red_any = red_any | opt_ctl[i].led_red;
  end
  // Length of the current echo wait
  always_comb iso_nxt = c0.rx_isolate ? iso_r + 1 : 0;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      iso_r <= 0;
    else
      iso_r <= iso_nxt;
  sequence s_tx_idle;
    opt_tx_start[0] && c0.echo_ret_en && !c0.rx_isolate && !c0.seg;
  endsequence
  sequence s_off;
    !c0.echo_ret_en ##1 !c0.echo_ret_en;
  endsequence
  property p_iso;
    s_tx_idle |=> c0.rx_isolate;
  endproperty
  a_iso: assert property (p_iso)
    else $error("receiver not isolated after transmit");
  property p_clr;
    c0.rx_isolate && r0.echo && !r0.err |-> ##[1:2] !c0.rx_isolate;
  endproperty
  a_clr: assert property (p_clr)
    else $error("isolation kept after good echo");
  property p_wait;
    iso_r <= (ECHO_WAIT_BITS + 2) * bc;
  endproperty
  a_wait: assert property (p_wait)
    else $error("echo wait overran its limit");
  property p_off;
    s_off |-> !c0.seg && !c0.rx_isolate;
  endproperty
  a_off: assert property (p_off)
    else $error("unmonitored port isolated or segmented");
  property p_red;
    $rose(c0.seg) |-> c0.led_red;
  endproperty
  a_red: assert property (p_red)
    else $error("segmented port not red");
  property p_fault;
    fault_contact == $past(red_any);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault contact does not follow red indicators");
  property p_el;
    !el_seg_req |=> !el_seg;
  endproperty
  a_el: assert property (p_el)
    else $error("electrical segmentation without request");
  property p_test;
    c0.send_test |=> !c0.send_test;
  endproperty
  a_test: assert property (p_test)
    else $error("test frame request longer than one cycle");
endmodule // flm_chk

bind flm_top flm_chk #(
  .NPORT         (NPORT),
  .ECHO_WAIT_BITS(ECHO_WAIT_BITS)
) chk_u (
  .hclk         (hclk),
  .hresetn      (hresetn),
  .rate_sel     (rate_sel),
  .opt_rx       (opt_rx),
  .opt_tx_start (opt_tx_start),
  .opt_ctl      (opt_ctl),
  .el_seg_req   (el_seg_req),
  .el_seg       (el_seg),
  .fault_contact(fault_contact)
);

// ==== flm_peer.sv ====
/*
  Peer repeater across the fiber of optical port 0.
  Assumes local transmit and test requests as one-cycle pulses.
*/
`timescale 1ns/1ns
module flm_peer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        tx,
  input  wire logic        send_test,
  input  wire logic        mon,
  input  wire logic        alive,
  input  wire logic [1:0]  dly,
  output flm_pkg::flm_rx_t rx
);
  logic [2:0] cnt;
  logic       tst;
  logic       hit;
  assign hit = cnt == 3'h1;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt <= 3'h0;
      tst <= 1'b0;
      rx  <= '0;
    end
    else
    begin
      if ((tx || send_test) && alive)
      begin
        cnt <= {1'b0, dly} + 3'h1;
        tst <= send_test;
      end
      else if (cnt != 3'h0)
        cnt <= cnt - 3'h1;
      // Answer frame; between answers peer_mon shows the inverse of mon, other fields stay low
      rx.frame    <= hit;
      rx.echo     <= hit && mon;
      rx.err      <= 1'b0;
      rx.test     <= hit && tst && mon;
      rx.peer_mon <= hit ? mon : ~mon;
      rx.peer_ok  <= hit;
    end
endmodule // flm_peer

// ==== tb_top.sv ====
/*
  Testbench of the fiber link monitor: registers, echo, faults.
  Assumes peer on port 0, port 1 left dark.
*/
`timescale 1ns/1ns
module tb_top;
  logic             hclk = 1'b0;
  logic             hresetn = 1'b0;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic             tx = 1'b0;
  logic             el_seg_req = 1'b0;
  logic             el_seg;
  logic             fault_contact;
  logic             irq;
  logic             mon = 1'b1;
  logic             alive = 1'b1;
  logic [1:0]       dly = 2'h0;
  logic             rd_dp = 1'b0;
  logic [31:0]      m;
  logic [31:0]      exp_q[$];
  integer           seed = 32'h4B05;
  int               failures = 0;
  int               num_checks = 0;
  int               cyc = 0;
  flm_pkg::flm_rx_t rx0;
  flm_pkg::flm_po_t [1:0] opt_ctl;
  wire flm_pkg::flm_rx_t [1:0] opt_rx = {6'h00, rx0};

  always #10 hclk = ~hclk;

  flm_top #(
    .ECHO_WAIT_BITS(4),
    .TEST_INT_BITS (8)
  ) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rate_sel(4'h9), .opt_rx(opt_rx),
    .opt_tx_start({1'b0, tx}), .opt_ctl(opt_ctl),
    .el_seg_req(el_seg_req), .el_seg(el_seg),
    .fault_contact(fault_contact), .irq(irq)
  );
  flm_peer peer_u (
    .hclk(hclk), .hresetn(hresetn), .tx(tx),
    .send_test(opt_ctl[0].send_test), .mon(mon), .alive(alive),
    .dly(dly), .rx(rx0)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Single word transfer; for reads d is the expected data
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= !w;
    if (!w)
      exp_q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  task automatic txp();
    @(posedge hclk);
    tx <= 1'b1;
    @(posedge hclk);
    tx <= 1'b0;
  endtask

  // Read data check and run limit
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (rd_dp && hreadyout)
    begin
      chk(hrdata, exp_q.pop_front());
      chk(hresp, 1'b0);
    end
    if (cyc == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, flm_pkg::OFF_CTRL, 32'h3);
    chk(opt_ctl[0].echo_ret_en, 1'b1);
    bus(0, flm_pkg::OFF_STATUS, 32'h0);
    bus(0, 12'h010, 32'h0);
    bus(1, flm_pkg::OFF_IRQ_MASK, 32'h3F);
    m = $random(seed);
    dly <= m[1:0];
    txp();
    repeat (30) @(posedge hclk);
    chk(opt_ctl[0].seg, 1'b0);
    repeat (300) if (!opt_ctl[1].seg) @(posedge hclk);
    repeat (3) @(posedge hclk);
    bus(0, flm_pkg::OFF_STATUS, 32'h10202);
    chk(irq, 1'b1);
    bus(1, flm_pkg::OFF_CTRL, 32'h1);
    repeat (4) @(posedge hclk);
    bus(0, flm_pkg::OFF_STATUS, 32'h0);
    chk(opt_ctl[1].echo_ret_en, 1'b0);
    bus(0, flm_pkg::OFF_IRQ_STAT, 32'h38);
    bus(1, flm_pkg::OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    bus(1, flm_pkg::OFF_IRQ_MASK, 32'h3F);
    bus(1, flm_pkg::OFF_IRQ_STAT, 32'h3F);
    bus(0, flm_pkg::OFF_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    alive <= 1'b0;
    txp();
    repeat (300) if (!opt_ctl[0].seg) @(posedge hclk);
    chk(opt_ctl[0].led_red, 1'b1);
    repeat (3) @(posedge hclk);
    bus(0, flm_pkg::OFF_STATUS, 32'h10101);
    bus(0, flm_pkg::OFF_IRQ_STAT, 32'h3);
    alive <= 1'b1;
    repeat (400) if (opt_ctl[0].seg) @(posedge hclk);
    chk(opt_ctl[0].seg, 1'b0);
    repeat (3) @(posedge hclk);
    bus(0, flm_pkg::OFF_IRQ_STAT, 32'h7);
    bus(1, flm_pkg::OFF_IRQ_STAT, 32'h7);
    mon <= 1'b0;
    txp();
    repeat (40) @(posedge hclk);
    chk(opt_ctl[0].echo_ret_en, 1'b0);
    chk(opt_ctl[0].seg, 1'b0);
    repeat (8)
    begin
      m = $random(seed);
      bus(1, flm_pkg::OFF_CTRL, {23'h0, m[0], 6'h0, 2'h1});
      el_seg_req <= m[1];
      repeat (3) @(posedge hclk);
      chk(el_seg, m[1] & ~m[0]);
    end
    report_and_stop();
  end
endmodule // tb_top
